//--- hdl/pmdb_bus_if.sv
`timescale 1ns/1ps
// Interface: decoded register access between bus slave and register core
interface pmdb_bus_if;
  logic wr_pulse;
  logic [2:0] wr_index;
  logic [15:0] wr_data;
  logic [1:0] wr_be;
  logic [2:0] rd_index;
  logic [15:0] rd_data;
  modport slave (output wr_pulse, output wr_index, output wr_data, output wr_be,
    output rd_index, input rd_data);
  modport core (input wr_pulse, input wr_index, input wr_data, input wr_be,
    input rd_index, output rd_data);
endinterface

//--- hdl/pmdb_pkg.sv
// Package: register map, field layout and reset values of the module disable bank
package pmdb_pkg;
  // Word offsets of the six disable registers (byte addresses)
  localparam logic [4:0] OFS_CTL_1 = 5'h00;
  localparam logic [4:0] OFS_CTL_2 = 5'h04;
  localparam logic [4:0] OFS_CTL_3 = 5'h08;
  localparam logic [4:0] OFS_CTL_4 = 5'h0c;
  localparam logic [4:0] OFS_CTL_6 = 5'h10;
  localparam logic [4:0] OFS_CTL_7 = 5'h14;
  localparam int NUM_REGS = 6;
  localparam int REG_W = 16;
  // Writable-bit masks; all other bits are unimplemented
  localparam logic [15:0] MASK_CTL_1 = 16'hfefb;
  localparam logic [15:0] MASK_CTL_2 = 16'h0f0f;
  localparam logic [15:0] MASK_CTL_3 = 16'h0482;
  localparam logic [15:0] MASK_CTL_4 = 16'h000c;
  localparam logic [15:0] MASK_CTL_6 = 16'h0700;
  localparam logic [15:0] MASK_CTL_7 = 16'h0018;
  localparam logic [15:0] RST_CTL = 16'h0000;
  // Field positions
  localparam int POS_TIMER1 = 11;
  localparam int POS_QUAD = 10;
  localparam int POS_MPWM = 9;
  localparam int POS_TWOWIRE1 = 7;
  localparam int POS_SERIAL2 = 6;
  localparam int POS_SERIAL1 = 5;
  localparam int POS_SYNC2 = 4;
  localparam int POS_SYNC1 = 3;
  localparam int POS_CAN = 1;
  localparam int POS_ADC = 0;
  localparam int POS_CAPTURE1 = 8;
  localparam int POS_COMPARE1 = 0;
  localparam int POS_COMPARATOR = 10;
  localparam int POS_CHECKSUM = 7;
  localparam int POS_TWOWIRE2 = 1;
  localparam int POS_REFCLK = 3;
  localparam int POS_CHARGE = 2;
  localparam int POS_PWMGEN1 = 8;
  localparam int POS_DMA = 4;
  localparam int POS_TRIGGER = 3;
  // Number of gated module enables
  localparam int NUM_GATES = 32;
endpackage

//--- hdl/pmdb_regcore.sv
`timescale 1ns/1ps
// Register core: six masked disable registers with byte-lane writes
module pmdb_regcore (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Decoded access
  pmdb_bus_if.core bus,
  // Register contents
  output logic [6*16-1:0] o_regs
);
  typedef struct packed {
    logic [5:0][15:0] ctl;
  } pmdb_core_t;
  localparam logic [5:0][15:0] MASKS = {pmdb_pkg::MASK_CTL_7, pmdb_pkg::MASK_CTL_6,
    pmdb_pkg::MASK_CTL_4, pmdb_pkg::MASK_CTL_3, pmdb_pkg::MASK_CTL_2, pmdb_pkg::MASK_CTL_1};
  pmdb_core_t st_reg;
  pmdb_core_t st_next;
  logic [15:0] lane_mask;

  always_comb begin
    st_next = st_reg;
    lane_mask = {{8{bus.wr_be[1]}}, {8{bus.wr_be[0]}}};
    for (int i = 0; i < 6; i++) begin
      // Unimplemented bits never store implemented ones are R/W
      if (bus.wr_pulse && bus.wr_index == 3'(i)) begin
        st_next.ctl[i] = (st_reg.ctl[i] & ~lane_mask) | (bus.wr_data & lane_mask & MASKS[i]);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg.ctl <= {6{pmdb_pkg::RST_CTL}};
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    bus.rd_data = 16'h0000;
    if (bus.rd_index < 3'd6) begin
      bus.rd_data = st_reg.ctl[bus.rd_index] & MASKS[bus.rd_index];
    end
  end

  assign o_regs = st_reg.ctl;
endmodule

//--- hdl/pmdb_top.sv
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
// Top: peripheral module disable bank with Avalon-MM slave and gated enables
// Contract
// - Control 1 bits 15..11 disable timers 5..1 when set.
// - Control 1 bit 10 disables quadrature decoder, bit 9 motor PWM; motor variants.
// - Control 1 bits 7..3: two-wire 1, serial 2, serial 1, sync 2, sync 1.
// - Control 1 bit 1 disables CAN where present; bit 0 disables ADC.
// - Control 2 bits 11..8 disable input capture units 4..1.
// - Control 2 bits 3..0 disable output compare units 4..1.
// - Control 3 bit 10 comparator, bit 7 checksum, bit 1 two-wire 2.
// - Control 4 bit 3 reference clock output, bit 2 charge timer.
// - Control 6 bits 10..8 disable PWM generators 3..1; motor variants.
// - Control 7 bit 4 disables all four DMA channels together.
// - Control 7 bit 3 disables the trigger generator.
// - Unassigned bits ignore writes and read zero.
// - Assigned bits are read/write and clear to zero at reset.
// - Disabled module gets no clock and its register access is blocked.
// - Enable changes one instruction cycle after the bit changes.
// - Module enabled only if bit clear and module present on variant.
module pmdb_top #(
  parameter bit HAS_MOTOR = 1'b1,
  parameter bit HAS_CAN = 1'b1,
  parameter int INSTR_CLKS = 1
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  // Per-module clock enables, bit order as in the enable map below
  output logic [31:0] o_mod_clk_en,
  // Per-module register access enables
  output logic [31:0] o_mod_acc_en
);
  // Delay counter is four bits wide
  if (INSTR_CLKS < 1 || INSTR_CLKS > 15) begin : g_bad_instr_clks
    $error("INSTR_CLKS out of range");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_DONE} pmdb_bus_st_t;

  typedef struct packed {
    pmdb_bus_st_t bus_st;
    logic [31:0] rdata;
    logic wait_n;
    logic [1:0] resp;
    logic [31:0] en_now;
    logic [31:0] clk_en;
    logic [3:0] dly_cnt;
  } pmdb_top_t;

  pmdb_bus_if bus ();
  pmdb_top_t st_reg;
  pmdb_top_t st_next;
  logic [6*16-1:0] regs;
  logic [15:0] c1, c2, c3, c4, c6, c7;
  logic [31:0] want_en;
  logic hit;
  logic [2:0] idx;

  pmdb_regcore u_core (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .bus(bus),
    .o_regs(regs)
  );

  assign c1 = regs[15:0];
  assign c2 = regs[31:16];
  assign c3 = regs[47:32];
  assign c4 = regs[63:48];
  assign c6 = regs[79:64];
  assign c7 = regs[95:80];

  // Address decode
  always_comb begin
    hit = 1'b1;
    idx = 3'd7;
    unique case (i_avs_address)
      pmdb_pkg::OFS_CTL_1: idx = 3'd0;
      pmdb_pkg::OFS_CTL_2: idx = 3'd1;
      pmdb_pkg::OFS_CTL_3: idx = 3'd2;
      pmdb_pkg::OFS_CTL_4: idx = 3'd3;
      pmdb_pkg::OFS_CTL_6: idx = 3'd4;
      pmdb_pkg::OFS_CTL_7: idx = 3'd5;
      default: hit = 1'b0;
    endcase
  end

  assign bus.wr_index = idx;
  assign bus.rd_index = idx;
  assign bus.wr_data = i_avs_writedata[15:0];
  assign bus.wr_be = i_avs_byteenable[1:0];
  assign bus.wr_pulse = (st_reg.bus_st == ST_IDLE) && i_avs_write && hit;

  // Module enable map: bit set means module runs
  always_comb begin
    want_en = 32'h0000_0000;
    for (int t = 0; t < 5; t++) begin
      want_en[t] = ~c1[pmdb_pkg::POS_TIMER1 + t];
    end
    want_en[5] = ~c1[pmdb_pkg::POS_QUAD] & HAS_MOTOR;
    want_en[6] = ~c1[pmdb_pkg::POS_MPWM] & HAS_MOTOR;
    want_en[7] = ~c1[pmdb_pkg::POS_TWOWIRE1];
    want_en[8] = ~c1[pmdb_pkg::POS_SERIAL2];
    want_en[9] = ~c1[pmdb_pkg::POS_SERIAL1];
    want_en[10] = ~c1[pmdb_pkg::POS_SYNC2];
    want_en[11] = ~c1[pmdb_pkg::POS_SYNC1];
    want_en[12] = ~c1[pmdb_pkg::POS_CAN] & HAS_CAN;
    want_en[13] = ~c1[pmdb_pkg::POS_ADC];
    for (int u = 0; u < 4; u++) begin
      want_en[14 + u] = ~c2[pmdb_pkg::POS_CAPTURE1 + u];
      want_en[18 + u] = ~c2[pmdb_pkg::POS_COMPARE1 + u];
    end
    want_en[22] = ~c3[pmdb_pkg::POS_COMPARATOR];
    want_en[23] = ~c3[pmdb_pkg::POS_CHECKSUM];
    want_en[24] = ~c3[pmdb_pkg::POS_TWOWIRE2];
    want_en[25] = ~c4[pmdb_pkg::POS_REFCLK];
    want_en[26] = ~c4[pmdb_pkg::POS_CHARGE];
    for (int p = 0; p < 3; p++) begin
      want_en[27 + p] = ~c6[pmdb_pkg::POS_PWMGEN1 + p] & HAS_MOTOR;
    end
    // One shared bit drives all four channels
    want_en[30] = ~c7[pmdb_pkg::POS_DMA];
    want_en[31] = ~c7[pmdb_pkg::POS_TRIGGER];
  end

  always_comb begin
    st_next = st_reg;
    // Bus handshake: waitrequest low one cycle after the request is seen
    unique case (st_reg.bus_st)
      ST_IDLE: begin
        st_next.wait_n = 1'b0;
        if (i_avs_read || i_avs_write) begin
          st_next.bus_st = ST_ACK;
          st_next.wait_n = 1'b1;
          st_next.resp = hit ? 2'b00 : 2'b10;
          st_next.rdata = (i_avs_read && hit) ? {16'h0000, bus.rd_data} : 32'h0000_0000;
        end
      end
      ST_ACK: begin
        st_next.bus_st = ST_DONE;
        st_next.wait_n = 1'b0;
      end
      ST_DONE: begin
        st_next.bus_st = ST_IDLE;
      end
    endcase
    // Enables follow the bits after one instruction cycle of delay
    if (want_en != st_reg.en_now) begin
      if (st_reg.dly_cnt == 4'(INSTR_CLKS - 1)) begin
        st_next.en_now = want_en;
        st_next.dly_cnt = 4'h0;
      end else begin
        st_next.dly_cnt = st_reg.dly_cnt + 4'h1;
      end
    end else begin
      st_next.dly_cnt = 4'h0;
    end
    st_next.clk_en = st_next.en_now;
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg.bus_st <= ST_IDLE;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.wait_n <= 1'b0;
      st_reg.resp <= 2'b00;
      st_reg.en_now <= 32'h0000_0000;
      st_reg.clk_en <= 32'h0000_0000;
      st_reg.dly_cnt <= 4'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = ~st_reg.wait_n;
  assign o_avs_response = st_reg.resp;
  assign o_mod_clk_en = st_reg.clk_en;
  // Access blocked whenever the clock is stopped
  assign o_mod_acc_en = st_reg.clk_en;
endmodule

//--- tb/pmdb_top_sva.sv
// Checker: bus timing, read masking and enable delay of the disable bank
`timescale 1ns/1ps
module pmdb_top_sva #(
  parameter int INSTR_CLKS = 1
) (
  // Clock, reset and bus
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic [1:0] o_avs_response,
  // Enables
  input wire logic [31:0] o_mod_clk_en,
  input wire logic [31:0] o_mod_acc_en
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  logic hit;
  logic mapped;
  assign hit = !o_avs_waitrequest;
  assign mapped = i_avs_address[1:0] == 2'b00 && i_avs_address <= pmdb_pkg::OFS_CTL_7;
  property p_wait_one; hit |=> o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_answer; (i_avs_read || i_avs_write) |-> ##[0:3] hit; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_upper; hit |-> o_avs_readdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper half set");
  property p_acc; o_mod_acc_en == o_mod_clk_en; endproperty
  a_acc: assert property (p_acc) else $error("access enable differs");
  property p_unmap;
    hit && i_avs_read && !mapped |-> o_avs_response == 2'b10 && o_avs_readdata == 32'h0000_0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_map; hit && mapped |-> o_avs_response == 2'b00; endproperty
  a_map: assert property (p_map) else $error("mapped error resp");
  property p_ctl4;
    hit && i_avs_read && i_avs_address == pmdb_pkg::OFS_CTL_4
      |-> (o_avs_readdata[15:0] & ~pmdb_pkg::MASK_CTL_4) == 16'h0000;
  endproperty
  a_ctl4: assert property (p_ctl4) else $error("reserved bit read");
  property p_timer;
    hit && i_avs_write && i_avs_byteenable[1] && i_avs_address == pmdb_pkg::OFS_CTL_1
      |-> ##2 o_mod_clk_en[4:0] == ~$past(i_avs_writedata[15:11], 2);
  endproperty
  a_timer: assert property (p_timer) else $error("timer enables");
  property p_dma;
    hit && i_avs_write && i_avs_byteenable[0] && i_avs_address == pmdb_pkg::OFS_CTL_7
      |-> ##2 o_mod_clk_en[30] != $past(i_avs_writedata[4], 2);
  endproperty
  a_dma: assert property (p_dma) else $error("dma enable");
endmodule
bind pmdb_top pmdb_top_sva #(.INSTR_CLKS(INSTR_CLKS)) i_sva (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
  .o_mod_clk_en(o_mod_clk_en), .o_mod_acc_en(o_mod_acc_en));

//--- tb/pmdb_top_tb.sv
// Testbench: register access, masking and enable gating of the disable bank
`timescale 1ns/1ps
module pmdb_top_tb;
  localparam logic [15:0] MSK [6] = '{pmdb_pkg::MASK_CTL_1, pmdb_pkg::MASK_CTL_2,
    pmdb_pkg::MASK_CTL_3, pmdb_pkg::MASK_CTL_4, pmdb_pkg::MASK_CTL_6, pmdb_pkg::MASK_CTL_7};
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [3:0] be = 4'h0;
  logic [31:0] rdat, clk_en, got;
  logic [31:0] acc_en, en_ack;
  logic wait_rq;
  logic [1:0] resp, gr;
  logic [15:0] m [6];
  int n_errors = 0;
  int cmp_count = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  pmdb_top i_dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq), .o_avs_response(resp),
    .o_mod_clk_en(clk_en), .o_mod_acc_en(acc_en));
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  // Every implemented enable is the inverse of its stored bit
  function automatic logic [31:0] exp_en();
    return ~{m[5][3], m[5][4], m[4][10:8], m[3][2], m[3][3],
      m[2][1], m[2][7], m[2][10], m[1][3:0], m[1][11:8],
      m[0][0], m[0][1], m[0][3], m[0][4], m[0][5], m[0][6],
      m[0][7], m[0][9], m[0][10], m[0][15:11]};
  endfunction
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d,
      input logic [1:0] b);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    adr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {16'h0000, d};
    be <= {2'b00, b};
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    got = rdat;
    gr = resp;
    en_ack = clk_en;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wait_rq !== 1'b0) begin
      chk(32'h0, 32'h1, "bus timeout");
      tally_and_finish();
    end
  endtask
  task automatic wreg(input int i, input logic [15:0] d, input logic [1:0] b);
    logic [15:0] bm;
    bm = {{8{b[1]}}, {8{b[0]}}};
    bus(1'b1, 5'(i * 4), d, b);
    m[i] = (m[i] & ~bm) | (d & bm & MSK[i]);
  endtask
  task automatic rreg(input int i);
    bus(1'b0, 5'(i * 4), 16'h0000, 2'b00);
    chk(got, {16'h0000, m[i]}, "readback");
    chk({30'h0, gr}, 32'h0000_0000, "resp");
  endtask
  // Enable output lands at the edge the write completes; checked one edge later
  task automatic chk_en();
    @(posedge i_clk_sys);
    #1;
    chk(clk_en, exp_en(), "enables");
    chk(acc_en, exp_en(), "access enables");
  endtask
  initial begin
    int i;
    for (int k = 0; k < 6; k++) begin
      m[k] = 16'h0000;
    end
    void'($urandom(32'hb865_a950));
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rreg(k);
    end
    chk_en();
    for (int k = 0; k < 6; k++) begin
      wreg(k, 16'hffff, 2'b11);
      rreg(k);
    end
    chk_en();
    wreg(0, 16'h0000, 2'b01);
    rreg(0);
    bus(1'b1, 5'h1c, 16'hffff, 2'b11);
    bus(1'b0, 5'h1c, 16'h0000, 2'b00);
    chk(got, 32'h0000_0000, "unmapped data");
    chk({30'h0, gr}, 32'h0000_0002, "unmapped resp");
    // Sampled at the acknowledge edge, one edge after the register took the write
    wreg(5, 16'h0000, 2'b01);
    chk({31'h0, en_ack[31]}, 32'h0000_0000, "early enable");
    chk_en();
    repeat (40) begin
      i = $urandom_range(5);
      wreg(i, 16'($urandom), 2'($urandom));
      rreg(i);
      chk_en();
    end
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      m[k] = 16'h0000;
      rreg(k);
    end
    chk_en();
    tally_and_finish();
  end
endmodule
